/* File: pkg/emb_consts.svh */
// Offsets, field positions and reset values of the external bus port
// Function
// - Standby drops mastership and floats bus outputs
// - Master drives 18-bit address, held between accesses
// - Master drives data only on writes; ignores otherwise
// - Keepers hold last driven data in standby
// - Attribute lines default to one-hot priority selects
// - Priority disable bit passes encoded attribute value
// - Master asserts active-low read strobe on reads
// - Master asserts active-low write strobe on writes
// - Acknowledge ignored outside own external cycles
// - Cycle ends one period after acknowledge seen
// - Wait states are max of minimum and acknowledge
// - Zero programmed wait states cannot be extended
// - Request follows external bus need or hold bit only
// - Reset deasserts request, arbiter back to slave
// - Request hold bit; standby request per hold bit
// - After grant wait busy free, then assert busy
// - Grant withdrawn releases bus after current cycle
// - Arbitration enable bit; grant and busy synchronised
// - Master may park, keeping busy asserted
// - Busy released on grant withdrawal by driving high, then floating
// - Bus clock leads core clock quarter cycle
`ifndef EMB_CONSTS_SVH
`define EMB_CONSTS_SVH

`define EMB_OFF_OMR    5'h00
`define EMB_OFF_BUSCTL 5'h04
`define EMB_OFF_ADDR   5'h08
`define EMB_OFF_WDATA  5'h0C
`define EMB_OFF_CMD    5'h10
`define EMB_OFF_CTRL   5'h14
`define EMB_OFF_STATUS 5'h18
`define EMB_OFF_RDATA  5'h1C

`define EMB_OMR_NOPRIO 14
`define EMB_OMR_ARB_EN 13
`define EMB_OMR_TRC_EN 6
`define EMB_BUS_HOLD   8
`define EMB_CMD_GO     0
`define EMB_CMD_WR     1
`define EMB_CMD_AT_LSB 4
`define EMB_CTRL_STBY  0

`define EMB_ADDR_W     18
`define EMB_DATA_W     24
`define EMB_ATTR_W     4
`define EMB_ADDR_RST   18'h00000
`define EMB_DATA_RST   24'h000000
`define EMB_WORD_ZERO  32'h00000000

`endif

/* File: pkg/emb_pkg.sv */
// Types of the external bus port
package emb_pkg;
	typedef enum logic [1:0] {
		ARB_SLAVE,
		ARB_WAIT_BUSY,
		ARB_MASTER,
		ARB_RELEASE
	} emb_arb_t;

	typedef enum logic [1:0] {
		CYC_IDLE,
		CYC_ACCESS,
		CYC_END
	} emb_cyc_t;

	typedef struct packed {
		logic       pend;
		logic       wr;
		logic [3:0] attr;
	} emb_cmd_t;
endpackage

/* File: verilog/emb_port.sv */
// External memory expansion port with Avalon-MM register slave
//
// The address map and the Avalon-MM register port were decided locally.
`timescale 1ns/1ns
`include "emb_consts.svh"

module emb_port #(
	parameter int WS_W = 4
) (
	// Clock and reset
	input  wire logic                   ref_clk,
	input  wire logic                   rst_n,
	// Avalon-MM slave
	input  wire logic [4:0]             avs_address,
	input  wire logic                   avs_read,
	input  wire logic                   avs_write,
	input  wire logic [31:0]            avs_writedata,
	output logic      [31:0]            avs_readdata,
	output logic                        avs_waitrequest,
	// Address bus
	output logic      [`EMB_ADDR_W-1:0] ext_addr,
	output logic                        ext_addr_oe,
	// Data bus
	input  wire logic [`EMB_DATA_W-1:0] ext_data_i,
	output logic      [`EMB_DATA_W-1:0] ext_data_o,
	output logic                        ext_data_oe,
	output logic                        data_keep,
	// Attributes and strobes
	output logic      [`EMB_ATTR_W-1:0] addr_attribute,
	output logic                        addr_attribute_oe,
	output logic                        read_n,
	output logic                        read_n_oe,
	output logic                        write_n,
	output logic                        write_n_oe,
	input  wire logic                   transfer_ack_n,
	// Arbitration
	output logic                        bus_request_n,
	input  wire logic                   bus_grant_n,
	input  wire logic                   bus_busy_n_i,
	output logic                        bus_busy_n_o,
	output logic                        bus_busy_n_oe,
	// Clocks out
	output logic                        core_clock_out,
	output logic                        bus_clock,
	output logic                        bus_clock_oe
);
	// Counter and register field both hold the wait-state value
	if (WS_W < 1 || WS_W > 8) begin : g_ws_check
		$error("WS_W must lie between 1 and 8");
	end

	// One-hot pick of the lowest set attribute line
	function automatic logic [3:0] emb_prio(input logic [3:0] a);
		logic [3:0] r;
		r = 4'h0;
		if (a[0])
			r = 4'h1;
		else if (a[1])
			r = 4'h2;
		else if (a[2])
			r = 4'h4;
		else if (a[3])
			r = 4'h8;
		return r;
	endfunction

	logic                   wait_q;
	logic [31:0]            rdata_bus_q;
	logic                   prio_dis_q, arb_en_q, trace_en_q, hold_q, stby_q;
	logic [WS_W-1:0]        ws_q;
	logic [`EMB_ADDR_W-1:0] sw_addr_q, addr_q;
	logic [`EMB_DATA_W-1:0] sw_wdata_q, dout_q, rdata_q;
	emb_pkg::emb_cmd_t      cmd_q;
	emb_pkg::emb_arb_t      arb_q;
	emb_pkg::emb_cyc_t      cyc_q;
	logic                   mst_q, busy_o_q, busy_oe_q;
	logic [WS_W-1:0]        cnt_q;
	logic [3:0]             attr_q;
	logic                   rd_n_q, wr_n_q, doe_q, last_out_q, keep_q;
	logic                   breq_n_q;
	logic [1:0]             ph_q;
	logic                   core_q, bclk_q, bclk_oe_q;
	logic                   ack_s1, ack_s2, gnt_s1, gnt_s2, busy_s1, busy_s2;
	logic [`EMB_DATA_W-1:0] d_s1, d_s2;
	logic                   take, wr_en, start;
	logic [1:0]             ph_d;

	assign take  = (avs_read | avs_write) & wait_q;
	assign wr_en = avs_write & ~wait_q;
	// Start only while granted so start and release never meet
	assign start = (cyc_q == emb_pkg::CYC_IDLE) &&
		(arb_q == emb_pkg::ARB_MASTER) && cmd_q.pend && !gnt_s2 &&
		!stby_q;
	assign ph_d  = ph_q + 2'h1;

	// Pin synchronisers; data input is read only at cycle end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_s1  <= 1'b1;
			ack_s2  <= 1'b1;
			gnt_s1  <= 1'b1;
			gnt_s2  <= 1'b1;
			busy_s1 <= 1'b1;
			busy_s2 <= 1'b1;
			d_s1    <= `EMB_DATA_RST;
			d_s2    <= `EMB_DATA_RST;
		end else begin
			ack_s1  <= transfer_ack_n;
			ack_s2  <= ack_s1;
			gnt_s1  <= bus_grant_n;
			gnt_s2  <= gnt_s1;
			busy_s1 <= bus_busy_n_i;
			busy_s2 <= busy_s1;
			d_s1    <= ext_data_i;
			d_s2    <= d_s1;
		end
	end

	// Answer one cycle after the request is seen, then rearm
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wait_q      <= 1'b1;
			rdata_bus_q <= `EMB_WORD_ZERO;
		end else begin
			wait_q <= ~take;
			if (take && avs_read) begin
				rdata_bus_q <= `EMB_WORD_ZERO;
				case (avs_address)
				`EMB_OFF_OMR: begin
					rdata_bus_q[`EMB_OMR_NOPRIO] <= prio_dis_q;
					rdata_bus_q[`EMB_OMR_ARB_EN] <= arb_en_q;
					rdata_bus_q[`EMB_OMR_TRC_EN] <= trace_en_q;
				end
				`EMB_OFF_BUSCTL: begin
					rdata_bus_q[WS_W-1:0]      <= ws_q;
					rdata_bus_q[`EMB_BUS_HOLD] <= hold_q;
				end
				`EMB_OFF_ADDR:
					rdata_bus_q[`EMB_ADDR_W-1:0] <= sw_addr_q;
				`EMB_OFF_WDATA:
					rdata_bus_q[`EMB_DATA_W-1:0] <= sw_wdata_q;
				`EMB_OFF_CMD: begin
					rdata_bus_q[`EMB_CMD_GO] <= cmd_q.pend;
					rdata_bus_q[`EMB_CMD_WR] <= cmd_q.wr;
					rdata_bus_q[`EMB_CMD_AT_LSB+:4] <= cmd_q.attr;
				end
				`EMB_OFF_CTRL:
					rdata_bus_q[`EMB_CTRL_STBY] <= stby_q;
				`EMB_OFF_STATUS: begin
					rdata_bus_q[0] <= mst_q;
					rdata_bus_q[1] <= (cyc_q != emb_pkg::CYC_IDLE);
					rdata_bus_q[2] <= cmd_q.pend;
					rdata_bus_q[3] <= ~breq_n_q;
					rdata_bus_q[4] <= busy_oe_q;
				end
				`EMB_OFF_RDATA:
					rdata_bus_q[`EMB_DATA_W-1:0] <= rdata_q;
				default:
					rdata_bus_q <= `EMB_WORD_ZERO;
				endcase
			end
		end
	end

	// Configuration registers
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			prio_dis_q <= 1'b0;
			arb_en_q   <= 1'b0;
			trace_en_q <= 1'b0;
			hold_q     <= 1'b0;
			stby_q     <= 1'b0;
			ws_q       <= '0;
			sw_addr_q  <= `EMB_ADDR_RST;
			sw_wdata_q <= `EMB_DATA_RST;
		end else if (wr_en) begin
			case (avs_address)
			`EMB_OFF_OMR: begin
				prio_dis_q <= avs_writedata[`EMB_OMR_NOPRIO];
				arb_en_q   <= avs_writedata[`EMB_OMR_ARB_EN];
				trace_en_q <= avs_writedata[`EMB_OMR_TRC_EN];
			end
			`EMB_OFF_BUSCTL: begin
				ws_q   <= avs_writedata[WS_W-1:0];
				hold_q <= avs_writedata[`EMB_BUS_HOLD];
			end
			`EMB_OFF_ADDR:
				sw_addr_q <= avs_writedata[`EMB_ADDR_W-1:0];
			`EMB_OFF_WDATA:
				sw_wdata_q <= avs_writedata[`EMB_DATA_W-1:0];
			`EMB_OFF_CTRL:
				stby_q <= avs_writedata[`EMB_CTRL_STBY];
			default: begin
			end
			endcase
		end
	end

	// Pending access; a new command is refused while one is pending
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cmd_q <= '0;
		end else if (start) begin
			cmd_q.pend <= 1'b0;
		end else if (wr_en && avs_address == `EMB_OFF_CMD &&
				avs_writedata[`EMB_CMD_GO] && !cmd_q.pend) begin
			cmd_q.pend <= 1'b1;
			cmd_q.wr   <= avs_writedata[`EMB_CMD_WR];
			cmd_q.attr <= avs_writedata[`EMB_CMD_AT_LSB+:4];
		end
	end

	// Arbitration
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			arb_q     <= emb_pkg::ARB_SLAVE;
			mst_q     <= 1'b0;
			busy_o_q  <= 1'b1;
			busy_oe_q <= 1'b0;
		end else if (stby_q) begin
			arb_q     <= emb_pkg::ARB_SLAVE;
			mst_q     <= 1'b0;
			busy_o_q  <= 1'b1;
			busy_oe_q <= 1'b0;
		end else begin
			case (arb_q)
			emb_pkg::ARB_SLAVE:
				if (arb_en_q && !gnt_s2)
					arb_q <= emb_pkg::ARB_WAIT_BUSY;
			emb_pkg::ARB_WAIT_BUSY:
				if (gnt_s2) begin
					arb_q <= emb_pkg::ARB_SLAVE;
				end else if (busy_s2) begin
					arb_q     <= emb_pkg::ARB_MASTER;
					mst_q     <= 1'b1;
					busy_o_q  <= 1'b0;
					busy_oe_q <= 1'b1;
				end
			// Stays master while granted, even with nothing to do
			emb_pkg::ARB_MASTER:
				if (gnt_s2 && cyc_q == emb_pkg::CYC_IDLE) begin
					arb_q    <= emb_pkg::ARB_RELEASE;
					mst_q    <= 1'b0;
					busy_o_q <= 1'b1;
				end
			emb_pkg::ARB_RELEASE: begin
				arb_q     <= emb_pkg::ARB_SLAVE;
				busy_oe_q <= 1'b0;
			end
			default:
				arb_q <= emb_pkg::ARB_SLAVE;
			endcase
		end
	end

	// External cycle
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cyc_q  <= emb_pkg::CYC_IDLE;
			cnt_q  <= '0;
			addr_q <= `EMB_ADDR_RST;
			attr_q <= 4'h0;
			dout_q <= `EMB_DATA_RST;
			rd_n_q <= 1'b1;
			wr_n_q <= 1'b1;
			doe_q  <= 1'b0;
		end else if (stby_q) begin
			cyc_q  <= emb_pkg::CYC_IDLE;
			rd_n_q <= 1'b1;
			wr_n_q <= 1'b1;
			doe_q  <= 1'b0;
		end else begin
			case (cyc_q)
			emb_pkg::CYC_IDLE:
				if (start) begin
					cyc_q  <= emb_pkg::CYC_ACCESS;
					cnt_q  <= '0;
					addr_q <= sw_addr_q;
					attr_q <= prio_dis_q ? cmd_q.attr :
						emb_prio(cmd_q.attr);
					rd_n_q <= cmd_q.wr;
					wr_n_q <= ~cmd_q.wr;
					doe_q  <= cmd_q.wr;
					if (cmd_q.wr)
						dout_q <= sw_wdata_q;
				end
			// Acknowledge only counts inside an own cycle
			emb_pkg::CYC_ACCESS: begin
				if (cnt_q != {WS_W{1'b1}})
					cnt_q <= cnt_q + 1'b1;
				if (cnt_q >= ws_q &&
					(ws_q == '0 || !ack_s2)) begin
					cyc_q  <= emb_pkg::CYC_END;
				end
			end
			emb_pkg::CYC_END: begin
				cyc_q  <= emb_pkg::CYC_IDLE;
				rd_n_q <= 1'b1;
				wr_n_q <= 1'b1;
				doe_q  <= 1'b0;
			end
			default:
				cyc_q <= emb_pkg::CYC_IDLE;
			endcase
		end
	end

	// Read capture and keeper state
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q    <= `EMB_DATA_RST;
			last_out_q <= 1'b0;
			keep_q     <= 1'b0;
		end else begin
			if (cyc_q == emb_pkg::CYC_END && !rd_n_q && !stby_q)
				rdata_q <= d_s2;
			if (doe_q)
				last_out_q <= 1'b1;
			else if (start && !cmd_q.wr)
				last_out_q <= 1'b0;
			keep_q <= stby_q & last_out_q;
		end
	end

	// Request tracks pending work or the hold bit, never mastership
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			breq_n_q <= 1'b1;
		else if (stby_q) begin
			if (!hold_q)
				breq_n_q <= 1'b1;
		end else
			breq_n_q <= ~(cmd_q.pend | hold_q |
				(cyc_q != emb_pkg::CYC_IDLE));
	end

	// Clock outputs at a quarter of ref_clk
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ph_q      <= 2'h0;
			core_q    <= 1'b0;
			bclk_q    <= 1'b0;
			bclk_oe_q <= 1'b0;
		end else begin
			ph_q      <= ph_d;
			core_q    <= ph_d[1];
			bclk_q    <= ph_d[1] ^ ph_d[0];
			// Falls with mastership at the release edge, not a cycle late
			bclk_oe_q <= mst_q & trace_en_q & ~stby_q &
				~(arb_q == emb_pkg::ARB_MASTER && gnt_s2 &&
				cyc_q == emb_pkg::CYC_IDLE);
		end
	end

	assign avs_readdata      = rdata_bus_q;
	assign avs_waitrequest   = wait_q;
	assign ext_addr          = addr_q;
	assign ext_addr_oe       = mst_q;
	assign ext_data_o        = dout_q;
	assign ext_data_oe       = doe_q;
	assign data_keep         = keep_q;
	assign addr_attribute    = attr_q;
	assign addr_attribute_oe = mst_q;
	assign read_n            = rd_n_q;
	assign read_n_oe         = mst_q;
	assign write_n           = wr_n_q;
	assign write_n_oe        = mst_q;
	assign bus_request_n     = breq_n_q;
	assign bus_busy_n_o      = busy_o_q;
	assign bus_busy_n_oe     = busy_oe_q;
	assign core_clock_out    = core_q;
	assign bus_clock         = bclk_q;
	assign bus_clock_oe      = bclk_oe_q;
endmodule

/* File: tb/emb_far.sv */
// Far side model: memory, acknowledge, arbiter grant and busy wire
`timescale 1ns/1ns
module emb_far (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	// Port side
	input  wire logic        read_n,
	input  wire logic        write_n,
	input  wire logic [23:0] ext_data_o,
	input  wire logic        bus_busy_n_o,
	input  wire logic        bus_busy_n_oe,
	// Bench controls
	input  wire logic        gnt,
	input  wire logic        other_n,
	input  wire logic [3:0]  ack_dly,
	// Toward the port
	output logic      [23:0] ext_data_i,
	output logic             transfer_ack_n,
	output logic             bus_busy_n_i,
	output logic             bus_grant_n,
	output logic      [23:0] mem_q
);
	logic [3:0] cnt_q;
	logic       strb;
	assign strb = !(read_n && write_n);
	assign bus_grant_n = !gnt;
	// Pull-up keeps the wire high when nobody drives it
	assign bus_busy_n_i = (bus_busy_n_oe ? bus_busy_n_o : 1'b1) && other_n;
	// Idle data shows the inverse, so stale data never passes
	assign ext_data_i = !read_n ? mem_q : ~mem_q;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 4'h0;
			transfer_ack_n <= 1'b1;
			mem_q <= 24'h000000;
		end else begin
			cnt_q <= strb ? cnt_q + 4'h1 : 4'h0;
			transfer_ack_n <= !(strb && cnt_q >= ack_dly);
			if (!write_n)
				mem_q <= ext_data_o;
		end
	end
endmodule

/* File: tb/emb_port_props.sv */
// Concurrent checks on the external bus port pins
`timescale 1ns/1ns
module emb_port_props (
	// Clock and reset
	input wire logic        ref_clk,
	input wire logic        rst_n,
	// Watched pins
	input wire logic [17:0] ext_addr,
	input wire logic        ext_addr_oe,
	input wire logic        ext_data_oe,
	input wire logic        addr_attribute_oe,
	input wire logic        read_n,
	input wire logic        read_n_oe,
	input wire logic        write_n,
	input wire logic        write_n_oe,
	input wire logic        transfer_ack_n,
	input wire logic        bus_request_n,
	input wire logic        bus_busy_n_i,
	input wire logic        bus_busy_n_o,
	input wire logic        bus_busy_n_oe,
	input wire logic        core_clock_out,
	input wire logic        bus_clock,
	input wire logic        bus_clock_oe
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	chk_oe_master:
	assert property (read_n_oe == ext_addr_oe && write_n_oe == ext_addr_oe
		&& addr_attribute_oe == ext_addr_oe) else $error("oe split");
	chk_addr_hold:
	assert property (ext_addr_oe && read_n && write_n && $past(read_n
		&& write_n) |-> $stable(ext_addr)) else $error("addr moved");
	chk_data_write:
	assert property (ext_data_oe |-> !write_n) else $error("data oe");
	chk_read_dir:
	assert property (!read_n |-> write_n && !ext_data_oe)
		else $error("read dir");
	chk_ack_end:
	assert property ((!transfer_ack_n && !(read_n && write_n))[*3]
		|-> ##[0:20] (read_n && write_n)) else $error("no end");
	chk_busy_take:
	assert property ($rose(ext_addr_oe) |-> bus_busy_n_oe && !bus_busy_n_o
		&& $past(bus_busy_n_i)) else $error("take");
	chk_busy_release:
	assert property ($fell(ext_addr_oe) && bus_busy_n_oe |-> bus_busy_n_o
		##1 !bus_busy_n_oe) else $error("release");
	chk_reset_request:
	assert property (disable iff (1'b0) !rst_n |-> bus_request_n
		&& !ext_addr_oe) else $error("reset");
	chk_bclk_lead:
	assert property (core_clock_out == $past(bus_clock)) else $error("lead");
	chk_bclk_master:
	assert property (bus_clock_oe |-> ext_addr_oe) else $error("bclk oe");
	cover property (!write_n);
	cover property (!read_n && transfer_ack_n ##1 !read_n);
	cover property ($fell(ext_addr_oe));
endmodule
bind emb_port emb_port_props chk_u (.*);

/* File: tb/tb_top.sv */
// Self-checking bench of the external bus port
`timescale 1ns/1ns
module tb_top;
	logic        ref_clk = 1'b0;
	logic        rst_n = 1'b1;
	logic [4:0]  avs_address = 5'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h00000000;
	logic [31:0] avs_readdata, q;
	logic [17:0] ext_addr, ad_seen;
	logic [23:0] ext_data_i, ext_data_o, mem_q;
	logic [3:0]  addr_attribute, at_seen, a;
	logic [3:0]  ack_dly = 4'h0;
	logic        gnt = 1'b0;
	logic        other_n = 1'b1;
	logic        avs_waitrequest, ext_addr_oe, ext_data_oe, data_keep;
	logic        addr_attribute_oe, read_n, read_n_oe, write_n, write_n_oe;
	logic        transfer_ack_n, bus_request_n, bus_grant_n, bus_busy_n_i;
	logic        bus_busy_n_o, bus_busy_n_oe, core_clock_out;
	logic        bus_clock, bus_clock_oe;
	int          len, num_errors, tests_run;
	emb_port dut_u (.*);
	emb_far far_u (.*);
	initial forever #25 ref_clk = ~ref_clk;
	// Record what each external cycle put on the pins
	always @(posedge ref_clk) begin
		if (!(read_n && write_n)) begin
			len <= len + 1;
			at_seen <= addr_attribute;
			ad_seen <= ext_addr;
		end
	end
	task automatic final_report;
		$display("errors %0d checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, e);
		tests_run++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic chk1(input logic g, e);
		chk({31'h0, g}, {31'h0, e});
	endtask
	task automatic av(input logic w, input logic [4:0] ad,
		input logic [31:0] d, output logic [31:0] r);
		int n;
		n = 0;
		@(posedge ref_clk);
		avs_address <= ad;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		do begin
			@(posedge ref_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 40);
		// A slave that never answers counts against the run
		if (avs_waitrequest !== 1'b0)
			chk1(avs_waitrequest, 1'b0);
		r = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task automatic wr(input logic [4:0] ad, input logic [31:0] d);
		logic [31:0] r;
		av(1'b1, ad, d, r);
	endtask
	// Poll status until nothing is pending or running
	task automatic fin;
		int n;
		n = 0;
		do begin
			av(1'b0, 5'h18, 32'h0, q);
			n++;
		end while (q[2:1] !== 2'b00 && n < 60);
		if (q[2:1] !== 2'b00)
			chk({30'h0, q[2:1]}, 32'h0);
		repeat (2) @(posedge ref_clk);
	endtask
	task automatic xc(input logic w, input logic [3:0] at, ws, dl);
		ack_dly <= dl;
		wr(5'h04, {28'h0000000, ws});
		len = 0;
		wr(5'h10, {24'h000000, at, 2'b00, w, 1'b1});
		fin;
	endtask
	// Whole run needs a few hundred cycles; this allows 20000 cycles
	initial begin
		#1000000;
		num_errors++;
		final_report;
	end
	initial begin
		// Async reset at time zero, so no output is unknown at an edge
		rst_n <= 1'b0;
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		chk1(bus_request_n, 1'b1);
		wr(5'h00, 32'h00002000);
		wr(5'h08, 32'h0002A5C3);
		wr(5'h0C, 32'h00C3A55A);
		other_n <= 1'b0;
		wr(5'h04, 32'h00000001);
		len = 0;
		wr(5'h10, 32'h00000033);
		repeat (3) @(posedge ref_clk);
		chk1(bus_request_n, 1'b0);
		gnt <= 1'b1;
		repeat (12) @(posedge ref_clk);
		chk1(ext_addr_oe, 1'b0);
		other_n <= 1'b1;
		fin;
		chk({8'h00, mem_q}, 32'h00C3A55A);
		chk({14'h0000, ad_seen}, 32'h0002A5C3);
		chk({28'h0000000, at_seen}, 32'h00000001);
		chk1(bus_request_n, 1'b1);
		chk1(ext_addr_oe, 1'b1);
		for (int p = 0; p < 2; p++) begin
			wr(5'h00, p ? 32'h00006000 : 32'h00002000);
			for (int i = 0; i < 2; i++) begin
				a = i ? 4'hC : 4'h6;
				xc(1'b1, a, 4'h1, 4'h1);
				chk({28'h0, at_seen}, {28'h0, p ? a : a & (~a + 4'h1)});
			end
		end
		xc(1'b0, 4'h1, 4'h1, 4'h6);
		av(1'b0, 5'h1C, 32'h0, q);
		chk(q, 32'h00C3A55A);
		chk({31'h0, len > 6}, 32'h1);
		xc(1'b0, 4'h1, 4'h5, 4'h0);
		chk({31'h0, len > 5}, 32'h1);
		xc(1'b0, 4'h1, 4'h0, 4'h8);
		chk(32'(len), 32'h2);
		wr(5'h00, 32'h00002040);
		repeat (3) @(posedge ref_clk);
		chk1(bus_clock_oe, 1'b1);
		gnt <= 1'b0;
		repeat (10) @(posedge ref_clk);
		chk({29'h0, ext_addr_oe, bus_busy_n_oe, bus_clock_oe}, 32'h0);
		gnt <= 1'b1;
		xc(1'b1, 4'h2, 4'h1, 4'h1);
		wr(5'h04, 32'h00000100);
		repeat (2) @(posedge ref_clk);
		chk1(bus_request_n, 1'b0);
		wr(5'h14, 32'h00000001);
		repeat (3) @(posedge ref_clk);
		chk({29'h0, ext_addr_oe, bus_busy_n_oe, data_keep}, 32'h1);
		chk1(bus_request_n, 1'b0);
		wr(5'h04, 32'h00000000);
		repeat (2) @(posedge ref_clk);
		chk1(bus_request_n, 1'b1);
		final_report;
	end
endmodule
